// ### clkc_top.sv
// system clock source control: pll sequencing, glitch-free selects, 32 kHz sources, monitor
`timescale 1ns/1ps
module clkc_top
    import clkc_pkg::*;
#(
    parameter int LOCK_CYCLES = LOCK_CYC,
    parameter int GAP_CYCLES = GAP_CYC
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_we,
    input wire logic i_re,
    output logic [31:0] o_rdata,
    // power state and analog status
    input wire logic i_deep_sleep,
    input wire logic i_core_supply_domain_off,
    input wire logic i_pll_lock,
    input wire logic i_hs_tick,
    input wire logic i_crystal_pin_b,
    // loop and main clock selects
    output logic o_pll_en,
    output logic o_sel_ring,
    output logic o_sel_pll,
    output logic o_gate_96,
    output logic o_gate_48,
    // derived ticks
    output logic o_mclk_tick,
    output logic o_periph_tick_48,
    output logic o_tick_2m,
    output logic o_tick_100k,
    output logic o_processor_clock_tick,
    // 32 kHz sources
    output logic [1:0] o_ref_src,
    output logic o_ref_from_xtal_pin,
    output logic o_silicon_osc_en,
    output logic o_crystal_en,
    output logic o_slow_domain_run,
    output logic o_core32_from_xtal,
    // monitor
    output logic o_mon_irq
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic turbo_fast_r;
    logic [7:0] proc_div_r;
    clkc_src_type src_r;
    logic [2:0] osc_r;
    logic core_xtal_r;
    logic [1:0] mon_ctrl_r;
    logic [15:0] mon_min_r, mon_max_r, mon_n_r;
    logic st_pass_r, st_fail_r;
    logic [31:0] rdata_r;

    function automatic logic ref_running(input clkc_src_type s, input logic [2:0] osc);
        unique case (s)
            SRC_SILICON: ref_running = osc[OSC_SIL_BIT];
            SRC_XTAL: ref_running = osc[OSC_XTAL_BIT];
            default: ref_running = 1'b1;
        endcase
    endfunction

    wire wr_turbo = i_we && (i_addr == OFS_TURBO);
    wire wr_proc = i_we && (i_addr == OFS_PROC);
    wire wr_src = i_we && (i_addr == OFS_SRC32);
    wire wr_osc = i_we && (i_addr == OFS_OSC);
    wire wr_core = i_we && (i_addr == OFS_CORE32);
    wire wr_mctl = i_we && (i_addr == OFS_MON_CTRL);
    wire wr_mlim = i_we && (i_addr == OFS_MON_LIM);
    wire wr_mn = i_we && (i_addr == OFS_MON_N);
    wire wr_stat = i_we && (i_addr == OFS_STATUS);
    wire src_change = wr_src && (i_wdata[1:0] != src_r);

    // ------------------------------------------------------------
    // loop sequencing
    // ------------------------------------------------------------
    clkc_pll_state_type st_r, st_nxt;
    logic [LW-1:0] lock_cnt_r;
    logic [7:0] gap_cnt_r;
    wire ref_ok = ref_running(src_r, osc_r);
    wire lock_done = ref_ok && (lock_cnt_r == LW'(LOCK_CYCLES - 1));
    wire stable = ref_ok && (i_pll_lock || lock_done);
    wire gap_done = (gap_cnt_r >= 8'(GAP_CYCLES));

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            PS_OFF: if (!i_deep_sleep && gap_done) st_nxt = PS_RING;
            PS_RING: if (stable) st_nxt = PS_GAP;
            PS_GAP: if (gap_done) st_nxt = PS_PLL;
            PS_PLL: st_nxt = PS_PLL;
            default: st_nxt = PS_OFF;
        endcase
        if (i_deep_sleep || src_change) begin
            st_nxt = PS_OFF;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_r <= PS_RING;
            lock_cnt_r <= '0;
            gap_cnt_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            if (st_r != PS_RING || !ref_ok || st_nxt != PS_RING) begin
                lock_cnt_r <= '0;
            end else if (!lock_done) begin
                lock_cnt_r <= LW'(lock_cnt_r + 1'b1);
            end
            if (st_nxt != st_r) begin
                gap_cnt_r <= 8'h00;
            end else if (!gap_done) begin
                gap_cnt_r <= 8'(gap_cnt_r + 8'h01);
            end
        end
    end

    assign o_pll_en = (st_r != PS_OFF);
    assign o_sel_ring = (st_r == PS_RING);
    assign o_sel_pll = (st_r == PS_PLL);

    // ------------------------------------------------------------
    // turbo select, break-before-make
    // ------------------------------------------------------------
    logic fast_act_r, fgate_r;
    logic [7:0] fgap_r;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            fast_act_r <= 1'b0;
            fgate_r <= 1'b1;
            fgap_r <= 8'h00;
        end else if (fgate_r) begin
            if (turbo_fast_r != fast_act_r) begin
                fgate_r <= 1'b0;
                fgap_r <= 8'h00;
            end
        end else if (fgap_r >= 8'(GAP_CYCLES)) begin
            fast_act_r <= turbo_fast_r;
            fgate_r <= 1'b1;
        end else begin
            fgap_r <= 8'(fgap_r + 8'h01);
        end
    end
    assign o_gate_96 = fgate_r && fast_act_r;
    assign o_gate_48 = fgate_r && !fast_act_r;

    // ------------------------------------------------------------
    // dividers
    // ------------------------------------------------------------
    clkc_tick_if tk();
    // the high-speed tick is held off while both sources are deselected
    assign tk.hs_tick = i_hs_tick && (o_sel_ring || o_sel_pll);
    assign tk.fast = fast_act_r && fgate_r;
    assign tk.proc_div = proc_div_r;

    clkc_div u_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .t(tk.div)
    );

    assign o_mclk_tick = tk.mclk_tick;
    assign o_periph_tick_48 = tk.tick_48;
    assign o_tick_2m = tk.tick_2m;
    assign o_tick_100k = tk.tick_100k;
    assign o_processor_clock_tick = tk.proc_tick;

    // ------------------------------------------------------------
    // 32 kHz sources
    // ------------------------------------------------------------
    assign o_ref_src = src_r;
    assign o_ref_from_xtal_pin = (src_r == SRC_SE_XTALPIN);
    assign o_silicon_osc_en = osc_r[OSC_SIL_BIT];
    assign o_crystal_en = osc_r[OSC_XTAL_BIT];
    assign o_slow_domain_run = ref_ok && (!i_core_supply_domain_off || osc_r[OSC_KEEP_BIT]);
    assign o_core32_from_xtal = core_xtal_r;

    // ------------------------------------------------------------
    // crystal monitor
    // ------------------------------------------------------------
    logic xtal_d_r;
    logic [15:0] per_r, good_r;
    wire mon_on = mon_ctrl_r[MON_EN_BIT] && mon_ctrl_r[MON_VALID_BIT];
    wire xtal_rise = i_crystal_pin_b && !xtal_d_r;
    wire per_ok = (per_r >= mon_min_r) && (per_r <= mon_max_r);
    wire too_long = tk.tick_48 && (per_r > mon_max_r);
    wire set_fail = mon_on && ((xtal_rise && !per_ok) || too_long);
    wire set_pass = mon_on && xtal_rise && per_ok && (16'(good_r + 16'h0001) >= mon_n_r);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            xtal_d_r <= 1'b0;
            per_r <= 16'h0000;
            good_r <= 16'h0000;
        end else begin
            xtal_d_r <= i_crystal_pin_b;
            if (!mon_on || xtal_rise) begin
                per_r <= 16'h0000;
            end else if (tk.tick_48 && per_r != 16'hFFFF) begin
                per_r <= 16'(per_r + 16'h0001);
            end
            if (!mon_on || set_fail) begin
                good_r <= 16'h0000;
            end else if (xtal_rise && per_ok && good_r != 16'hFFFF) begin
                good_r <= 16'(good_r + 16'h0001);
            end
        end
    end
    assign o_mon_irq = st_pass_r || st_fail_r;

    // ------------------------------------------------------------
    // register writes and reads
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            turbo_fast_r <= 1'b0;
            proc_div_r <= RST_PROC_DIV;
            src_r <= SRC_SILICON;
            osc_r <= 3'h0;
            core_xtal_r <= 1'b0;
            mon_ctrl_r <= 2'h0;
            mon_min_r <= RST_MON_MIN;
            mon_max_r <= RST_MON_MAX;
            mon_n_r <= RST_MON_N;
            st_pass_r <= 1'b0;
            st_fail_r <= 1'b0;
        end else begin
            if (wr_turbo) turbo_fast_r <= i_wdata[TURBO_FAST_BIT];
            if (wr_proc) proc_div_r <= i_wdata[7:0];
            if (wr_src) src_r <= clkc_src_type'(i_wdata[1:0]);
            if (wr_osc) osc_r <= i_wdata[2:0];
            if (wr_core) core_xtal_r <= i_wdata[CORE_XTAL_BIT];
            if (wr_mctl) mon_ctrl_r <= i_wdata[1:0];
            if (wr_mlim) begin
                mon_min_r <= i_wdata[15:0];
                mon_max_r <= i_wdata[LIM_MAX_LSB+15:LIM_MAX_LSB];
            end
            if (wr_mn) mon_n_r <= i_wdata[15:0];
            // a new event in the clearing cycle wins over the clear
            st_pass_r <= set_pass || (st_pass_r && !(wr_stat && i_wdata[ST_PASS_BIT]));
            st_fail_r <= set_fail || (st_fail_r && !(wr_stat && i_wdata[ST_FAIL_BIT]));
        end
    end

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_addr)
            OFS_TURBO: rd_mux[TURBO_FAST_BIT] = turbo_fast_r;
            OFS_PROC: rd_mux[7:0] = proc_div_r;
            OFS_SRC32: rd_mux[1:0] = src_r;
            OFS_OSC: rd_mux[2:0] = osc_r;
            OFS_CORE32: rd_mux[CORE_XTAL_BIT] = core_xtal_r;
            OFS_MON_CTRL: rd_mux[1:0] = mon_ctrl_r;
            OFS_MON_LIM: rd_mux = {mon_max_r, mon_min_r};
            OFS_MON_N: rd_mux[15:0] = mon_n_r;
            OFS_STATUS: begin
                rd_mux[ST_PASS_BIT] = st_pass_r;
                rd_mux[ST_FAIL_BIT] = st_fail_r;
                rd_mux[ST_STABLE_BIT] = stable;
                rd_mux[ST_PLL_BIT] = o_sel_pll;
                rd_mux[ST_FAST_BIT] = fast_act_r;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= i_re ? rd_mux : 32'h0000_0000;
        end
    end
    assign o_rdata = rdata_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sleep_pll_off: assert property (@(posedge i_clk) disable iff (i_rst)
        i_deep_sleep |=> !o_pll_en && !o_sel_pll)
        else $error("loop still on in deepest sleep");
    a_ring_until_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sel_ring && !stable) |=> !o_sel_pll)
        else $error("loop selected before stable");
    a_lock_timeout: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_sel_ring && lock_done && !i_deep_sleep && !src_change) |=> (st_r == PS_GAP))
        else $error("lock interval elapsed without handover");
    a_turbo_follow: assert property (@(posedge i_clk) disable iff (i_rst)
        (fgate_r && turbo_fast_r != fast_act_r && !wr_turbo) |=> !fgate_r [*2])
        else $error("turbo change did not open a gap");
    a_no_both_sel: assert property (@(posedge i_clk) disable iff (i_rst)
        !(o_sel_ring && o_sel_pll) && !(o_gate_96 && o_gate_48))
        else $error("two clock sources selected together");
    a_pll_gap_before: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_sel_pll) |-> $past(!o_sel_ring, 1) && $past(!o_sel_ring, 2))
        else $error("loop selected with no dead gap");
    a_src_restart: assert property (@(posedge i_clk) disable iff (i_rst)
        src_change |=> !o_pll_en ##1 !o_sel_pll)
        else $error("source change did not restart loop");
    a_pass_irq: assert property (@(posedge i_clk) disable iff (i_rst)
        set_pass |=> st_pass_r && o_mon_irq)
        else $error("pass not flagged");
    a_slow_keep: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_core_supply_domain_off && !osc_r[OSC_KEEP_BIT]) |-> !o_slow_domain_run)
        else $error("32 kHz domain runs with core off and no keep");
    a_fail_irq: assert property (@(posedge i_clk) disable iff (i_rst)
        set_fail |=> st_fail_r && o_mon_irq)
        else $error("fail not flagged");
    a_turbo_gap: assert property (@(posedge i_clk) disable iff (i_rst)
        ($rose(o_gate_96) || $rose(o_gate_48)) |->
            $past(!o_gate_96 && !o_gate_48, 1) && $past(!o_gate_96 && !o_gate_48, 2))
        else $error("turbo gate opened with no dead gap");
endmodule

// ### clkc_pkg.sv
// constants, field layout and types for the system clock source control block
package clkc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int LOCK_TIME_US = 3000;
    localparam int LOCK_CYC = LOCK_TIME_US * CLK_MHZ;
    localparam int GAP_CYC = 2;
    localparam int HS_PER_48M = 2;
    localparam int HS_PER_2M = 48;
    localparam int T48_PER_100K = 480;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TURBO = 8'h00;
    localparam logic [7:0] OFS_PROC = 8'h04;
    localparam logic [7:0] OFS_SRC32 = 8'h08;
    localparam logic [7:0] OFS_OSC = 8'h0C;
    localparam logic [7:0] OFS_CORE32 = 8'h10;
    localparam logic [7:0] OFS_MON_CTRL = 8'h14;
    localparam logic [7:0] OFS_MON_LIM = 8'h18;
    localparam logic [7:0] OFS_MON_N = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TURBO_FAST_BIT = 0;
    localparam int OSC_SIL_BIT = 0;
    localparam int OSC_XTAL_BIT = 1;
    localparam int OSC_KEEP_BIT = 2;
    localparam int CORE_XTAL_BIT = 0;
    localparam int MON_EN_BIT = 0;
    localparam int MON_VALID_BIT = 1;
    localparam int LIM_MAX_LSB = 16;
    localparam int ST_PASS_BIT = 0;
    localparam int ST_FAIL_BIT = 1;
    localparam int ST_STABLE_BIT = 2;
    localparam int ST_PLL_BIT = 3;
    localparam int ST_FAST_BIT = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PROC_DIV = 8'h01;
    localparam logic [15:0] RST_MON_MIN = 16'h0580;
    localparam logic [15:0] RST_MON_MAX = 16'h0620;
    localparam logic [15:0] RST_MON_N = 16'h0010;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_SILICON = 2'h0,
        SRC_XTAL = 2'h1,
        SRC_SE_GPIO = 2'h2,
        SRC_SE_XTALPIN = 2'h3
    } clkc_src_type;

    typedef enum logic [3:0] {
        PS_OFF = 4'h1,
        PS_RING = 4'h2,
        PS_GAP = 4'h4,
        PS_PLL = 4'h8
    } clkc_pll_state_type;
endpackage

// ### clkc_tick_if.sv
// tick strobes passed between the clock controller and its divider
`timescale 1ns/1ps
interface clkc_tick_if;
    logic hs_tick;
    logic fast;
    logic [7:0] proc_div;
    logic tick_48;
    logic tick_2m;
    logic tick_100k;
    logic mclk_tick;
    logic proc_tick;

    modport div (
        input hs_tick,
        input fast,
        input proc_div,
        output tick_48,
        output tick_2m,
        output tick_100k,
        output mclk_tick,
        output proc_tick
    );
    modport ctl (
        output hs_tick,
        output fast,
        output proc_div,
        input tick_48,
        input tick_2m,
        input tick_100k,
        input mclk_tick,
        input proc_tick
    );
endinterface

// ### clkc_div.sv
// divider producing the 48 MHz, 2 MHz, 100 kHz, main and processor tick strobes
`timescale 1ns/1ps
module clkc_div
    import clkc_pkg::*;
#(
    parameter int N48 = HS_PER_48M,
    parameter int N2M = HS_PER_2M,
    parameter int N100K = T48_PER_100K
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // tick strobes
    clkc_tick_if.div t
);
    // counts are in source ticks, not time, so an unlocked ring of any rate is fine
    function automatic logic [15:0] wrap_inc(input logic [15:0] cnt, input int lim);
        wrap_inc = (cnt >= 16'(lim - 1)) ? 16'h0000 : 16'(cnt + 16'h0001);
    endfunction

    logic [15:0] c48_r, c2m_r, c100k_r, cproc_r;
    logic [7:0] div_eff;
    wire last48 = t.hs_tick && (c48_r >= 16'(N48 - 1));
    wire last2m = t.hs_tick && (c2m_r >= 16'(N2M - 1));
    wire last100k = last48 && (c100k_r >= 16'(N100K - 1));
    assign div_eff = (t.proc_div == 8'h00) ? 8'h01 : t.proc_div;
    assign t.mclk_tick = t.fast ? t.hs_tick : last48;
    wire lastproc = t.mclk_tick && (cproc_r >= 16'({8'h00, div_eff} - 16'h0001));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            c48_r <= 16'h0000;
            c2m_r <= 16'h0000;
            c100k_r <= 16'h0000;
            cproc_r <= 16'h0000;
        end else begin
            if (t.hs_tick) begin
                c48_r <= wrap_inc(c48_r, N48);
                c2m_r <= wrap_inc(c2m_r, N2M);
            end
            if (last48) begin
                c100k_r <= wrap_inc(c100k_r, N100K);
            end
            if (t.mclk_tick) begin
                cproc_r <= wrap_inc(cproc_r, int'(div_eff));
            end
        end
    end

    assign t.tick_48 = last48;
    assign t.tick_2m = last2m;
    assign t.tick_100k = last100k;
    assign t.proc_tick = lastproc;

    a_tick2m_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
        t.tick_2m |=> !t.tick_2m [*8])
        else $error("2 MHz tick repeated too soon");
    a_tick100k_from48: assert property (@(posedge i_clk) disable iff (i_rst)
        t.tick_100k |-> t.tick_48)
        else $error("100 kHz tick not aligned to 48 MHz tick");
endmodule

// ### clkc_far_model.sv
// far-side model: high-speed source ticks, loop lock indication and crystal pin
`timescale 1ns/1ps
module clkc_far_model (
    // clock
    input wire logic i_clk,
    // controls from the block and the bench
    input wire logic i_pll_en,
    input wire logic i_lock_ok,
    input wire logic i_xtal_en,
    input wire logic [15:0] i_xtal_half,
    // analog side
    output logic o_hs_tick,
    output logic o_pll_lock,
    output logic o_crystal
);
    logic [15:0] xcnt_r = 16'h0000;
    logic [7:0] lcnt_r = 8'h00;
    initial o_hs_tick = 1'b1;
    initial o_pll_lock = 1'b0;
    initial o_crystal = 1'b0;
    // lock drops at once when the loop is switched off
    always @(posedge i_clk) begin
        lcnt_r <= (i_pll_en && i_lock_ok && lcnt_r != 8'h14) ? lcnt_r + 8'h01 : lcnt_r;
        if (!i_pll_en)
            lcnt_r <= 8'h00;
        o_pll_lock <= i_pll_en && lcnt_r == 8'h14;
    end
    // crystal only oscillates while enabled
    always @(posedge i_clk) begin
        xcnt_r <= (xcnt_r >= i_xtal_half - 16'h0001) ? 16'h0000 : xcnt_r + 16'h0001;
        if (i_xtal_en && xcnt_r >= i_xtal_half - 16'h0001)
            o_crystal <= ~o_crystal;
    end
endmodule

// ### tb_top.sv
// self-checking bench for the system clock source controller
`timescale 1ns/1ps
module tb_top;
    import clkc_pkg::*;
    localparam int LOCKN = 50;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_we = 1'b0;
    logic i_re = 1'b0;
    logic i_deep_sleep = 1'b0;
    logic i_core_supply_domain_off = 1'b0;
    logic lock_ok = 1'b0;
    logic [15:0] xhalf = 16'h0014;
    logic [31:0] o_rdata;
    logic hs, lock, xtal, pll_en, s_ring, s_pll, g96, g48, mclk, p48, t2m, t100k, ptk;
    logic [1:0] ref_src;
    logic xpin, sil_en, xtal_en, slow_run, c32x, irq;
    int n_mismatch = 0;
    int total_checks = 0;
    int c_m, c_p, c_48, c_2m, c_100k;
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        c_m += int'(mclk);
        c_p += int'(ptk);
        c_48 += int'(p48);
        c_2m += int'(t2m);
        c_100k += int'(t100k);
    end
    clkc_top #(.LOCK_CYCLES(LOCKN)) u_clkc_top (.i_clk(i_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
        .i_deep_sleep(i_deep_sleep), .i_core_supply_domain_off(i_core_supply_domain_off),
        .i_pll_lock(lock), .i_hs_tick(hs), .i_crystal_pin_b(xtal), .o_pll_en(pll_en),
        .o_sel_ring(s_ring), .o_sel_pll(s_pll), .o_gate_96(g96), .o_gate_48(g48),
        .o_mclk_tick(mclk), .o_periph_tick_48(p48), .o_tick_2m(t2m), .o_tick_100k(t100k),
        .o_processor_clock_tick(ptk), .o_ref_src(ref_src), .o_ref_from_xtal_pin(xpin),
        .o_silicon_osc_en(sil_en), .o_crystal_en(xtal_en), .o_slow_domain_run(slow_run),
        .o_core32_from_xtal(c32x), .o_mon_irq(irq));
    clkc_far_model u_clkc_far_model (.i_clk(i_clk), .i_pll_en(pll_en), .i_lock_ok(lock_ok),
        .i_xtal_en(xtal_en), .i_xtal_half(xhalf), .o_hs_tick(hs), .o_pll_lock(lock),
        .o_crystal(xtal));
    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_we <= 1'b1;
        @(posedge i_clk);
        i_we <= 1'b0;
        #1;
    endtask
    task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_re <= 1'b1;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 check(nm, e, o_rdata & m);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        check("ring", 32'h1, {s_pll, s_ring});
        check("osc_en", 32'h0, {sil_en, xtal_en});
        check("gates", 32'h1, {g96, g48});
        rc("proc", OFS_PROC, 32'hFF, 32'h1);
        rc("lim", OFS_MON_LIM, 32'hFFFFFFFF, 32'h06200580);
        rc("mon_n", OFS_MON_N, 32'hFFFF, 32'h10);
        wr(8'h24, 32'hFFFFFFFF);
        rc("unmapped", 8'h24, 32'hFFFFFFFF, 32'h0);
    endtask
    task automatic t_lock;
        repeat (80) @(posedge i_clk);
        #1 check("no_ref", 32'h1, s_ring);
        wr(OFS_OSC, 32'h1);
        check("sil_only", 32'h1, {xtal_en, sil_en});
        repeat (LOCKN - 10) @(posedge i_clk);
        #1 check("ring_wait", 32'h1, s_ring);
        for (int i = 0; i < 40 && s_pll !== 1'b1; i++) @(posedge i_clk);
        #1 check("loop_sel", 32'h1, {s_ring, s_pll});
        rc("st_loop", OFS_STATUS, 32'h8, 32'h8);
    endtask
    task automatic t_div(input bit fast);
        #1;
        c_m = 0;
        c_p = 0;
        c_48 = 0;
        c_2m = 0;
        c_100k = 0;
        repeat (1920) @(posedge i_clk);
        #1 check("t48", 32'd960, c_48);
        check("t2m", 32'd40, c_2m);
        check("t100k", 32'd2, c_100k);
        check("mclk", fast ? 32'd1920 : 32'd960, c_m);
        check("proc", fast ? 32'd480 : 32'd240, c_p);
    endtask
    task automatic t_turbo;
        wr(OFS_TURBO, 32'h1);
        for (int i = 0; i < 12 && g96 !== 1'b1; i++) @(posedge i_clk);
        #1 check("g96", 32'h2, {g96, g48});
        rc("st_fast", OFS_STATUS, 32'h10, 32'h10);
    endtask
    task automatic t_mon;
        wr(OFS_OSC, 32'h3);
        wr(OFS_MON_LIM, 32'h001E0000);
        wr(OFS_MON_N, 32'h3);
        wr(OFS_MON_CTRL, 32'h3);
        for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge i_clk);
        #1 check("irq_pass", 32'h1, irq);
        rc("st_pass", OFS_STATUS, 32'h3, 32'h1);
        wr(OFS_MON_CTRL, 32'h0);
        wr(OFS_STATUS, 32'h3);
        check("irq_clr", 32'h0, irq);
        xhalf <= 16'h0064;
        wr(OFS_MON_CTRL, 32'h3);
        for (int i = 0; i < 600 && irq !== 1'b1; i++) @(posedge i_clk);
        rc("st_fail", OFS_STATUS, 32'h3, 32'h2);
        wr(OFS_MON_CTRL, 32'h0);
    endtask
    task automatic t_src;
        lock_ok <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(OFS_SRC32, 32'(s));
            check("ref_src", 32'(s), ref_src);
            check("xtal_pin", 32'(s == 3), xpin);
        end
        @(posedge i_clk);
        #1 check("loop_off", 32'h0, {pll_en, s_pll});
        for (int i = 0; i < 10 && s_ring !== 1'b1; i++) @(posedge i_clk);
        #1 check("ring_back", 32'h1, s_ring);
        for (int i = 0; i < 40 && s_pll !== 1'b1; i++) @(posedge i_clk);
        #1 check("relock", 32'h1, s_pll);
    endtask
    task automatic t_sleep;
        @(posedge i_clk);
        i_deep_sleep <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1 check("sleep_off", 32'h0, {pll_en, s_pll});
        @(posedge i_clk);
        i_deep_sleep <= 1'b0;
        for (int i = 0; i < 10 && s_ring !== 1'b1; i++) @(posedge i_clk);
        #1 check("wake_ring", 32'h1, s_ring);
        for (int i = 0; i < 40 && s_pll !== 1'b1; i++) @(posedge i_clk);
        #1 check("wake_loop", 32'h1, s_pll);
    endtask
    task automatic t_slow;
        @(posedge i_clk);
        i_core_supply_domain_off <= 1'b1;
        @(posedge i_clk);
        #1 check("slow_stop", 32'h0, slow_run);
        wr(OFS_OSC, 32'h7);
        check("slow_keep", 32'h1, slow_run);
        @(posedge i_clk);
        i_core_supply_domain_off <= 1'b0;
        wr(OFS_CORE32, 32'h1);
        check("core32_x", 32'h1, c32x);
        wr(OFS_CORE32, 32'h0);
        check("core32_s", 32'h0, c32x);
    endtask
    // watchdog: the whole sequence needs under 12000 cycles
    initial begin
        repeat (30000) @(posedge i_clk);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1 t_reset();
        t_lock();
        wr(OFS_PROC, 32'h4);
        t_div(1'b0);
        t_turbo();
        t_div(1'b1);
        t_mon();
        t_src();
        t_sleep();
        t_slow();
        close_out();
    end
endmodule
